// ==== include/ddac_map.svh ====
// constants for the dual dac serial load logic: offsets, positions, presets
// assumes inclusion by bare name from the package and the design modules
`ifndef DDAC_MAP_SVH
`define DDAC_MAP_SVH

// serial word and dac register widths
`define DDAC_WORD_W 16
`define DDAC_DATA_W 12

// default positions of fields within the shifted word
`define DDAC_DATA_LSB 0
`define DDAC_ADDR_A_POS 13
`define DDAC_ADDR_B_POS 14
`define DDAC_MODE_POS 15

// preset values of the dac registers
`define DDAC_ZERO_SCALE 12'h000
`define DDAC_MID_SCALE 12'h800

// reset values
`define DDAC_SHIFT_RST 16'h0000
`define DDAC_EDGE_RST 4'hF

// edge detector lanes: serial clock, strobe a, strobe b, merged strobe
`define DDAC_EDGE_W 4
`define DDAC_LANE_SCLK 0
`define DDAC_LANE_LDA 1
`define DDAC_LANE_LDB 2
`define DDAC_LANE_LDANY 3

`endif

// ==== include/ddac_pkg.sv ====
// types shared by the dual dac serial load logic
// assumes ddac_map.svh on the include path
`include "ddac_map.svh"

package ddac_pkg;

	typedef enum logic {
		MODE_HW = 1'b0,
		MODE_SW = 1'b1
	} ddac_mode_t;

	typedef struct packed {
		logic [`DDAC_WORD_W-1:0] shiftReg;
		logic serialOut;
		logic [`DDAC_DATA_W-1:0] dacA;
		logic [`DDAC_DATA_W-1:0] dacB;
	} ddac_state_t;

	typedef struct packed {
		logic [`DDAC_EDGE_W-1:0] prev;
	} ddac_edge_t;

endpackage

// ==== core/ddac_edge_detect.sv ====
// edge detector for the serial clock and load strobe pins
// assumes inputs synchronous to sys_clk; one cycle pulse per edge
`include "ddac_map.svh"

module ddac_edge_detect (
	input wire logic sys_clk, // system clock
	input wire logic reset_n, // synchronous reset, active low
	input wire logic [`DDAC_EDGE_W-1:0] sig, // sampled levels
	output logic [`DDAC_EDGE_W-1:0] rise, // rising edge pulses
	output logic [`DDAC_EDGE_W-1:0] fall // falling edge pulses
);

	ddac_pkg::ddac_edge_t state_q;
	ddac_pkg::ddac_edge_t state_d;

	////////////////////////////////////////////////////////////////////////
	// reset high so idle-high strobes give no false edge after reset
	always_comb begin
		state_d = state_q;
		state_d.prev = sig;
	end

	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			state_q.prev <= `DDAC_EDGE_RST;
		end else begin
			state_q <= state_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	genvar i;
	generate
		for (i = 0; i < `DDAC_EDGE_W; i++) begin : g_lane
			assign rise[i] = sig[i] & ~state_q.prev[i];
			assign fall[i] = ~sig[i] & state_q.prev[i];
		end
	endgenerate

endmodule

// ==== core/ddac_serial_load.sv ====
// serial input and dac register load logic of a dual 12-bit dac
// assumes all pins sampled synchronous to sys_clk, serial clock slower

`include "ddac_map.svh"

////////////////////////////////////////////////////////////////////////////
module ddac_serial_load #(
	parameter int DATA_LSB = `DDAC_DATA_LSB, // lsb of data field
	parameter int ADDR_A_POS = `DDAC_ADDR_A_POS, // channel a select bit
	parameter int ADDR_B_POS = `DDAC_ADDR_B_POS, // channel b select bit
	parameter int MODE_POS = `DDAC_MODE_POS // decode mode bit
) (
	input wire logic sys_clk, // system clock, 100 MHz
	input wire logic reset_n, // synchronous reset, active low
	input wire logic serialClk, // serial clock pin, sampled
	input wire logic serialDataIn, // serial data pin
	input wire logic chipSelect_n, // chip select, active low
	input wire logic loadStrobeChanA_n, // load strobe a, active low
	input wire logic loadStrobeChanB_n, // load strobe b, active low
	input wire logic asyncPreset_n, // preset of dac registers, active low
	input wire logic presetMidscale, // preset level: 1 midscale, 0 zero
	output logic serialDataOut, // daisy chain output
	output logic [`DDAC_DATA_W-1:0] dacRegA, // channel a dac register
	output logic [`DDAC_DATA_W-1:0] dacRegB // channel b dac register
);

	ddac_pkg::ddac_state_t state_q;
	ddac_pkg::ddac_state_t state_d;

	logic [`DDAC_EDGE_W-1:0] pinLevel;
	logic [`DDAC_EDGE_W-1:0] pinRise;
	logic [`DDAC_EDGE_W-1:0] pinFall;
	logic shiftStep;
	logic fallA;
	logic fallB;
	logic fallAny;
	ddac_pkg::ddac_mode_t loadMode;
	logic [`DDAC_DATA_W-1:0] wordData;
	logic selA;
	logic selB;
	logic loadA;
	logic loadB;

	////////////////////////////////////////////////////////////////////////
	// edge detection of serial clock and strobes
	// merged lane is high only when both strobes are high, so tied pins
	// or one pin tied high both give a single falling edge
	assign pinLevel[`DDAC_LANE_SCLK] = serialClk;
	assign pinLevel[`DDAC_LANE_LDA] = loadStrobeChanA_n;
	assign pinLevel[`DDAC_LANE_LDB] = loadStrobeChanB_n;
	assign pinLevel[`DDAC_LANE_LDANY] = loadStrobeChanA_n & loadStrobeChanB_n;

	ddac_edge_detect u_edge (
		.sys_clk(sys_clk),
		.reset_n(reset_n),
		.sig(pinLevel),
		.rise(pinRise),
		.fall(pinFall)
	);

	assign shiftStep = pinRise[`DDAC_LANE_SCLK] & ~chipSelect_n;
	assign fallA = pinFall[`DDAC_LANE_LDA];
	assign fallB = pinFall[`DDAC_LANE_LDB];
	assign fallAny = pinFall[`DDAC_LANE_LDANY];

	////////////////////////////////////////////////////////////////////////
	// field decode of the word now held in the shift register
	assign loadMode = ddac_pkg::ddac_mode_t'(state_q.shiftReg[MODE_POS]);
	assign wordData = state_q.shiftReg[DATA_LSB +: `DDAC_DATA_W];
	assign selA = state_q.shiftReg[ADDR_A_POS];
	assign selB = state_q.shiftReg[ADDR_B_POS];

	// strobes are not gated by chip select
	always_comb begin
		loadA = 1'b0;
		loadB = 1'b0;
		case (loadMode)
			ddac_pkg::MODE_HW: begin
				loadA = fallA;
				loadB = fallB;
			end
			ddac_pkg::MODE_SW: begin
				loadA = fallAny & selA;
				loadB = fallAny & selB;
			end
			default: begin
				loadA = 1'b0;
				loadB = 1'b0;
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// next state
	// preset is a level held each sys_clk edge, so it acts with the serial
	// clock stopped; it is still one sys_clk late, the price of flop outputs
	always_comb begin
		state_d = state_q;
		if (shiftStep) begin
			state_d.shiftReg = {state_q.shiftReg[`DDAC_WORD_W-2:0],
				serialDataIn};
			state_d.serialOut = state_q.shiftReg[`DDAC_WORD_W-2];
		end
		if (!asyncPreset_n) begin
			if (presetMidscale) begin
				state_d.dacA = `DDAC_MID_SCALE;
				state_d.dacB = `DDAC_MID_SCALE;
			end else begin
				state_d.dacA = `DDAC_ZERO_SCALE;
				state_d.dacB = `DDAC_ZERO_SCALE;
			end
		end else begin
			// a word shifted while a strobe is low is not loaded until the next falling strobe edge
			if (loadA) begin
				state_d.dacA = wordData;
			end
			if (loadB) begin
				state_d.dacB = wordData;
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			state_q.shiftReg <= `DDAC_SHIFT_RST;
			state_q.serialOut <= 1'b0;
			state_q.dacA <= `DDAC_ZERO_SCALE;
			state_q.dacB <= `DDAC_ZERO_SCALE;
		end else begin
			state_q <= state_d;
		end
	end

	assign serialDataOut = state_q.serialOut;
	assign dacRegA = state_q.dacA;
	assign dacRegB = state_q.dacB;

	////////////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!reset_n);

	a_shift_one_bit: assert property (
		shiftStep |=> state_q.shiftReg ==
			{$past(state_q.shiftReg[`DDAC_WORD_W-2:0]), $past(serialDataIn)})
		else $error("shift register did not take one bit");

	a_cs_blocks_shift: assert property (
		chipSelect_n |=> $stable(state_q.shiftReg))
		else $error("shift register moved with chip select high");

	a_sdo_sixteen_late: assert property (
		shiftStep ##1 (!shiftStep && $stable(serialDataIn)) [*1]
			|-> serialDataOut == $past(state_q.shiftReg[`DDAC_WORD_W-2], 2))
		else $error("serial output not the bit sixteen clocks old");

	a_hold_without_load: assert property (
		(asyncPreset_n && !fallA && !fallB && !fallAny)
			|=> $stable(dacRegA) && $stable(dacRegB))
		else $error("dac register changed without a strobe edge");

	a_hw_load_a: assert property (
		(asyncPreset_n && !state_q.shiftReg[MODE_POS] && fallA)
			|=> dacRegA == $past(wordData))
		else $error("hardware load of channel a failed");

	a_hw_chan_indep: assert property (
		(asyncPreset_n && !state_q.shiftReg[MODE_POS] && fallB && !fallA)
			|=> $stable(dacRegA) && dacRegB == $past(wordData))
		else $error("channel b load disturbed channel a");

	a_sw_load_both: assert property (
		(asyncPreset_n && state_q.shiftReg[MODE_POS] && fallAny && selA && selB)
			|=> dacRegA == $past(wordData) && dacRegB == $past(wordData))
		else $error("software load of both channels failed");

	a_sw_no_select: assert property (
		(asyncPreset_n && state_q.shiftReg[MODE_POS] && !selA && !selB)
			|=> $stable(dacRegA) && $stable(dacRegB))
		else $error("software load with no address changed a register");

	a_preset_zero: assert property (
		(!asyncPreset_n && !presetMidscale)
			|=> dacRegA == `DDAC_ZERO_SCALE && dacRegB == `DDAC_ZERO_SCALE)
		else $error("preset did not clear dac registers");

	a_preset_mid: assert property (
		(!asyncPreset_n && presetMidscale)
			|=> dacRegA == `DDAC_MID_SCALE && dacRegB == `DDAC_MID_SCALE)
		else $error("preset did not load midscale");

	a_hw_load_b: assert property (
		(asyncPreset_n && !state_q.shiftReg[MODE_POS] && fallB)
			|=> dacRegB == $past(wordData))
		else $error("hardware load of channel b failed");

	a_sw_load_a: assert property (
		(asyncPreset_n && state_q.shiftReg[MODE_POS] && fallAny && selA && !selB)
			|=> dacRegA == $past(wordData) && $stable(dacRegB))
		else $error("software load of channel a alone failed");

	a_sdo_holds: assert property (
		!shiftStep |=> $stable(serialDataOut))
		else $error("serial output moved without a shift");

	c_hw_load_both: cover property (
		asyncPreset_n && !state_q.shiftReg[MODE_POS] && fallA && fallB);
	c_sw_load_b: cover property (
		asyncPreset_n && state_q.shiftReg[MODE_POS] && fallAny && selB && !selA);
	c_preset_mid: cover property (!asyncPreset_n && presetMidscale);
	c_shift_word: cover property (shiftStep ##1 !shiftStep [*2] ##1 shiftStep);

endmodule

// ==== test/ddac_host_model.sv ====
// host side model: shifts words in msb first and drives the load strobes
// assumes sys_clk of the device; all pins change just after a rising edge
module ddac_host_model (
	input wire logic sys_clk, // system clock
	input wire logic serialDataOut, // chain output of the device
	output logic serialClk, // serial clock, low outside frames
	output logic serialDataIn, // serial data
	output logic chipSelect_n, // chip select, active low
	output logic loadStrobeChanA_n, // load strobe a, active low
	output logic loadStrobeChanB_n // load strobe b, active low
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [15:0] chainSeen;
	initial begin
		serialClk = 1'b0;
		serialDataIn = 1'b0;
		chipSelect_n = 1'b1;
		loadStrobeChanA_n = 1'b1;
		loadStrobeChanB_n = 1'b1;
		chainSeen = 16'h0000;
	end
	////////////////////////////////////////////////////////////////////////
	// strobes stay high for the whole frame
	task automatic send_word(input logic [15:0] word, input logic sel);
		for (int i = 15; i >= 0; i--) begin
			@(posedge sys_clk);
			chipSelect_n <= ~sel;
			serialClk <= 1'b0;
			serialDataIn <= word[i];
			@(posedge sys_clk);
			serialClk <= 1'b1;
			// chain bit read before the shifting edge, as a next device would
			#1;
			chainSeen = {chainSeen[14:0], serialDataOut};
			@(posedge sys_clk);
		end
		@(posedge sys_clk);
		serialClk <= 1'b0;
		// released data line must not keep the last bit
		serialDataIn <= ~serialDataIn;
		chipSelect_n <= 1'b1;
	endtask
	task automatic pulse(input logic a, input logic b);
		@(posedge sys_clk);
		loadStrobeChanA_n <= ~a;
		loadStrobeChanB_n <= ~b;
		repeat (2) @(posedge sys_clk);
		loadStrobeChanA_n <= 1'b1;
		loadStrobeChanB_n <= 1'b1;
		repeat (2) @(posedge sys_clk);
	endtask
endmodule

// ==== test/dual_dac_serial_load_logic_tb.sv ====
// self-checking bench of the dual dac serial load logic
// assumes the host model drives all serial and strobe pins
module dual_dac_serial_load_logic_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic sys_clk = 1'b0;
	logic reset_n = 1'b0;
	logic serialClk, serialDataIn, chipSelect_n, serialDataOut;
	logic loadStrobeChanA_n, loadStrobeChanB_n;
	logic asyncPreset_n = 1'b1;
	logic presetMidscale = 1'b0;
	logic [11:0] dacRegA, dacRegB, expA, expB;
	int failures = 0;
	int compares = 0;
	int cycles = 0;
	ddac_serial_load i_ddac_serial_load (.sys_clk(sys_clk),
		.reset_n(reset_n), .serialClk(serialClk),
		.serialDataIn(serialDataIn), .chipSelect_n(chipSelect_n),
		.loadStrobeChanA_n(loadStrobeChanA_n),
		.loadStrobeChanB_n(loadStrobeChanB_n),
		.asyncPreset_n(asyncPreset_n), .presetMidscale(presetMidscale),
		.serialDataOut(serialDataOut), .dacRegA(dacRegA), .dacRegB(dacRegB));
	ddac_host_model i_ddac_host_model (.sys_clk(sys_clk),
		.serialDataOut(serialDataOut), .serialClk(serialClk),
		.serialDataIn(serialDataIn), .chipSelect_n(chipSelect_n),
		.loadStrobeChanA_n(loadStrobeChanA_n),
		.loadStrobeChanB_n(loadStrobeChanB_n));
	initial begin
		forever #5 sys_clk = ~sys_clk;
	end
	////////////////////////////////////////////////////////////////////////
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		compares++;
		if (seen !== exp) begin
			failures++;
			$display("[ERR] %0t: got %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic check_dacs();
		check({4'h0, dacRegA}, {4'h0, expA});
		check({4'h0, dacRegB}, {4'h0, expB});
	endtask
	task automatic finish_test();
		$display("compares %0d failures %0d", compares, failures);
		if (failures == 0 && compares > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	// shifting alone must leave both dac registers alone
	task automatic load(input logic [15:0] w, input logic a, input logic b,
		input logic load_strobe_chan_a_n, input logic load_strobe_chan_b_n);
		i_ddac_host_model.send_word(w, 1'b1);
		#1;
		check_dacs();
		i_ddac_host_model.pulse(a, b);
		if (load_strobe_chan_a_n) expA = w[11:0];
		if (load_strobe_chan_b_n) expB = w[11:0];
		#1;
		check_dacs();
	endtask
	task automatic preset(input logic mid, input logic [11:0] lvl);
		@(posedge sys_clk);
		presetMidscale <= mid;
		asyncPreset_n <= 1'b0;
		repeat (2) @(posedge sys_clk);
		asyncPreset_n <= 1'b1;
		@(posedge sys_clk);
		#1;
		expA = lvl;
		expB = lvl;
		check_dacs();
	endtask
	task automatic test_preset();
		preset(1'b1, 12'h800);
		preset(1'b0, 12'h000);
		$display("test preset done");
	endtask
	task automatic test_hw_load();
		load(16'h0ABC, 1'b1, 1'b0, 1'b1, 1'b0);
		load(16'h0123, 1'b0, 1'b1, 1'b0, 1'b1);
		load(16'h05A5, 1'b1, 1'b1, 1'b1, 1'b1);
		// address bits set but mode low: strobes still pick
		load(16'h6456, 1'b1, 1'b0, 1'b1, 1'b0);
		$display("test hw_load done");
	endtask
	task automatic test_sw_load();
		load(16'h8111, 1'b1, 1'b1, 1'b0, 1'b0);
		load(16'hA222, 1'b1, 1'b1, 1'b1, 1'b0);
		load(16'hC333, 1'b1, 1'b1, 1'b0, 1'b1);
		load(16'hE444, 1'b0, 1'b1, 1'b1, 1'b1);
		load(16'hC555, 1'b1, 1'b0, 1'b0, 1'b1);
		$display("test sw_load done");
	endtask
	task automatic test_chain();
		i_ddac_host_model.send_word(16'h5AC3, 1'b1);
		i_ddac_host_model.send_word(16'h9F0F, 1'b0);
		i_ddac_host_model.send_word(16'h0E71, 1'b1);
		check(i_ddac_host_model.chainSeen, 16'h5AC3);
		// strobe with select high still loads
		i_ddac_host_model.pulse(1'b1, 1'b1);
		expA = 12'hE71;
		expB = 12'hE71;
		#1;
		check_dacs();
		$display("test chain done");
	endtask
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 8000) begin
			failures++;
			$display("[ERR] %0t: timeout", $time);
			finish_test();
		end
	end
	initial begin
		expA = 12'h000;
		expB = 12'h000;
		repeat (10) @(posedge sys_clk);
		reset_n <= 1'b1;
		@(posedge sys_clk);
		#1;
		check_dacs();
		test_preset();
		test_hw_load();
		test_sw_load();
		test_chain();
		finish_test();
	end
endmodule
